// ===== src/card_supply_converter_ctrl.sv
// APB-controlled sequencer for the card supply step up/down converter
module card_supply_converter_ctrl
   import card_supply_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic card_present_pin,
   input wire logic overload_sense,
   input wire logic vout_in_spec,
   output conv_ctrl_t conv_ctrl,
   output logic converter_clk,
   output logic irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [9:0] trip_pct(input logic [1:0] step, input logic raise);
      logic [9:0] mult;
      mult = 10'(step) + 10'd1;
      trip_pct = TRIP_BASE_PCT * mult + (raise ? TRIP_RAISE_PCT * mult : 10'd0);
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers: three stages, accepted when stages 2 and 3 agree
   // ----------------------------------------------------------------
   logic [2:0] pres_s, ovl_s, spec_s;
   logic present_r, overload_r, in_spec_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pres_s <= 3'h0;
         ovl_s <= 3'h0;
         spec_s <= 3'h0;
      end else begin
         pres_s <= {pres_s[1:0], card_present_pin};
         ovl_s <= {ovl_s[1:0], overload_sense};
         spec_s <= {spec_s[1:0], vout_in_spec};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         present_r <= 1'b0;
         overload_r <= 1'b0;
         in_spec_r <= 1'b0;
      end else begin
         if (pres_s[1] == pres_s[2]) present_r <= pres_s[2];
         if (ovl_s[1] == ovl_s[2]) overload_r <= ovl_s[2];
         if (spec_s[1] == spec_s[2]) in_spec_r <= spec_s[2];
      end
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic wr_acc, setup, mapped;
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign mapped = hit(paddr, OFS_CONTROL) || hit(paddr, OFS_CONFIG) || hit(paddr, OFS_CONVERTER)
      || hit(paddr, OFS_STATUS) || hit(paddr, OFS_IRQ_STATUS) || hit(paddr, OFS_IRQ_MASK);
   assign pslverr = psel && penable && !mapped;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [1:0] level_r, step_r;
   logic [3:0] prescale_r;
   logic raise_r, topology_r;
   logic [2:0] irq_mask_r, irq_stat_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_r <= LEVEL_RST;
         prescale_r <= PRESCALE_RST;
         step_r <= STEP_RST;
         raise_r <= 1'b0;
         topology_r <= 1'b0;
         irq_mask_r <= IRQ_MASK_RST;
      end else if (wr_acc) begin
         if (hit(paddr, OFS_CONFIG)) level_r <= pwdata[POS_LEVEL +: 2];
         if (hit(paddr, OFS_CONVERTER)) begin
            prescale_r <= pwdata[POS_PRESCALE +: 4];
            step_r <= pwdata[POS_STEP +: 2];
            raise_r <= pwdata[POS_RAISE];
            topology_r <= pwdata[POS_TOPOLOGY];
         end
         if (hit(paddr, OFS_IRQ_MASK)) irq_mask_r <= pwdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Converter sequencer
   // ----------------------------------------------------------------
   conv_state_t state_r, state_nxt;
   logic on_r;
   logic [8:0] shut_cnt_r;
   logic on_wr;

   assign on_wr = wr_acc && hit(paddr, OFS_CONTROL);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF: begin
            if (on_r && present_r) state_nxt = ST_START;
         end
         ST_START: begin
            if (!present_r || !on_r) state_nxt = ST_SHUT;
            else if (in_spec_r && !overload_r) state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (!present_r || !on_r) state_nxt = ST_SHUT;
            else if (overload_r) state_nxt = ST_TRIP;
         end
         ST_SHUT: begin
            if (shut_cnt_r == 9'(SHUTDOWN_CYC - 1)) state_nxt = ST_OFF;
         end
         ST_TRIP: begin
            if (on_r && present_r) state_nxt = ST_START;
         end
         default: state_nxt = ST_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_r <= ST_OFF;
      else state_r <= state_nxt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) shut_cnt_r <= 9'h000;
      else if (state_r == ST_SHUT) shut_cnt_r <= shut_cnt_r + 9'h001;
      else shut_cnt_r <= 9'h000;
   end

   // Hardware clear wins over a software set: removal and trips are safety events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) on_r <= 1'b0;
      // Cleared while the card is absent and on entry to the tripped state, not while in it, so software can restart from it
      else if (!present_r || (state_nxt == ST_TRIP && state_r != ST_TRIP)) on_r <= 1'b0;
      else if (on_wr) on_r <= pwdata[POS_ON];
   end

   // ----------------------------------------------------------------
   // Status flags and analog controls
   // ----------------------------------------------------------------
   logic ready_r, ovc_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_r <= 1'b0;
         ovc_r <= 1'b0;
      end else begin
         ready_r <= (state_nxt == ST_RUN) && in_spec_r;
         ovc_r <= (state_nxt == ST_TRIP);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_ctrl <= '0;
      end else begin
         conv_ctrl.enable <= (state_nxt == ST_START) || (state_nxt == ST_RUN);
         conv_ctrl.regulator_mode <= topology_r;
         conv_ctrl.sensor_enable <= (state_nxt == ST_RUN);
         conv_ctrl.five_volt <= (level_r == LEVEL_5V);
         conv_ctrl.level <= level_r;
         conv_ctrl.startup_step <= step_r;
         conv_ctrl.trip_pct <= trip_pct(step_r, raise_r && state_nxt == ST_RUN);
      end
   end

   // Converter clock: half period of prescale + 1 cycles, stopped while off
   logic [3:0] div_cnt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 4'h0;
         converter_clk <= 1'b0;
      end else if (!conv_ctrl.enable) begin
         div_cnt_r <= 4'h0;
         converter_clk <= 1'b0;
      end else if (div_cnt_r >= prescale_r) begin
         div_cnt_r <= 4'h0;
         converter_clk <= !converter_clk;
      end else begin
         div_cnt_r <= div_cnt_r + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts: sticky, write one to clear, set wins
   // ----------------------------------------------------------------
   logic [2:0] irq_evt, irq_clr;
   logic present_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) present_d_r <= 1'b0;
      else present_d_r <= present_r;
   end

   assign irq_evt = {present_d_r && !present_r, state_nxt == ST_TRIP && state_r != ST_TRIP,
                     state_nxt == ST_RUN && state_r != ST_RUN};
   assign irq_clr = (wr_acc && hit(paddr, OFS_IRQ_STATUS)) ? pwdata[2:0] : 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_stat_r <= 3'h0;
      else irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // ----------------------------------------------------------------
   // Read data, captured in the setup phase
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            OFS_CONTROL: prdata[POS_ON] <= on_r;
            OFS_CONFIG: prdata[POS_LEVEL +: 2] <= level_r;
            OFS_CONVERTER: prdata[7:0] <= {topology_r, raise_r, step_r, prescale_r};
            OFS_STATUS: begin
               prdata[POS_READY] <= ready_r;
               prdata[POS_OVC] <= ovc_r;
               prdata[POS_PRESENT] <= present_r;
               prdata[POS_STATE +: 3] <= state_r;
            end
            OFS_IRQ_STATUS: prdata[2:0] <= irq_stat_r;
            OFS_IRQ_MASK: prdata[2:0] <= irq_mask_r;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence removal_s;
      $fell(present_r) && state_r == ST_RUN;
   endsequence

   chk_absent_no_start: assert property (!present_r |=> !conv_ctrl.enable || state_r == ST_SHUT)
      else $error("converter enabled with card absent");
   chk_removal_shutdown: assert property (removal_s |=> state_r == ST_SHUT ##1 !conv_ctrl.enable)
      else $error("no shutdown after card removal");
   chk_prescale_reset: assert property ($rose(presetn) |-> prescale_r == PRESCALE_RST)
      else $error("prescaler reset value wrong");
   chk_trip_raise: assert property (state_r == ST_RUN && raise_r && $stable(step_r) && state_nxt == ST_RUN
      |=> conv_ctrl.trip_pct == (TRIP_BASE_PCT + TRIP_RAISE_PCT) * (10'($past(step_r)) + 10'd1))
      else $error("raised trip level wrong");
   chk_ovc_flag: assert property (state_r == ST_RUN && present_r && on_r && overload_r
      |=> ovc_r && !ready_r)
      else $error("overcurrent flag not set");
   chk_step_out: assert property ($changed(step_r) |=> conv_ctrl.startup_step == $past(step_r))
      else $error("startup step not forwarded");
   chk_five_volt: assert property (level_r == LEVEL_5V |=> conv_ctrl.five_volt)
      else $error("5 V not selected");
   chk_trip_scale: assert property (state_nxt == ST_START
      |=> conv_ctrl.trip_pct == TRIP_BASE_PCT * (10'($past(step_r)) + 10'd1))
      else $error("trip level not scaled by step");
   chk_start_quiet: assert property (state_r == ST_START |-> !conv_ctrl.sensor_enable && !ovc_r)
      else $error("sensor or flag active during startup");
   chk_flags_exclusive: assert property (!(ready_r && ovc_r))
      else $error("ready and overcurrent both set");
   chk_reset_flags: assert property ($rose(presetn) |-> !on_r && !ready_r && !ovc_r)
      else $error("flags not cleared by reset");

   sequence trip_entry_s;
      state_r == ST_RUN && present_r && on_r && overload_r;
   endsequence

   sequence restart_req_s;
      state_r == ST_TRIP && present_r && on_wr && pwdata[POS_ON];
   endsequence

   chk_trip_clears_on: assert property (trip_entry_s |=> state_r == ST_TRIP && !on_r && !conv_ctrl.enable)
      else $error("trip did not switch the converter off");
   chk_trip_restart: assert property (restart_req_s
      |=> on_r ##1 ((state_r == ST_START && !ovc_r) || !present_r))
      else $error("no restart from tripped state");
   chk_run_sensor_on: assert property (state_r == ST_RUN |-> conv_ctrl.sensor_enable)
      else $error("overcurrent sensor off while running");
   chk_shut_quiet: assert property (state_r == ST_SHUT |-> !conv_ctrl.enable && !ready_r && !ovc_r)
      else $error("converter or flags active in shutdown");

endmodule

// ===== src/card_supply_pkg.sv
// Constants, types and register map of the card supply converter control block
package card_supply_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_CONVERTER = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_ON = 0;
   localparam int POS_LEVEL = 0;
   localparam int POS_PRESCALE = 0;
   localparam int POS_STEP = 4;
   localparam int POS_RAISE = 6;
   localparam int POS_TOPOLOGY = 7;
   localparam int POS_READY = 0;
   localparam int POS_OVC = 1;
   localparam int POS_PRESENT = 2;
   localparam int POS_STATE = 4;
   localparam int IRQ_READY = 0;
   localparam int IRQ_OVC = 1;
   localparam int IRQ_REMOVED = 2;

   // ----------------------------------------------------------------
   // Reset values and the 5 V level code
   // ----------------------------------------------------------------
   localparam logic [1:0] LEVEL_RST = 2'h0;
   localparam logic [1:0] LEVEL_5V = 2'h3;
   localparam logic [3:0] PRESCALE_RST = 4'h0;
   localparam logic [1:0] STEP_RST = 2'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // ----------------------------------------------------------------
   // Trip level in percent of the 100 mA base
   // ----------------------------------------------------------------
   localparam logic [9:0] TRIP_BASE_PCT = 10'd100;
   localparam logic [9:0] TRIP_RAISE_PCT = 10'd20;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int SHUTDOWN_NS = 10000;
   localparam int SHUTDOWN_CYC = (SHUTDOWN_NS + CLK_NS - 1) / CLK_NS;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_START = 3'b001,
      ST_RUN = 3'b011,
      ST_SHUT = 3'b010,
      ST_TRIP = 3'b110
   } conv_state_t;

   typedef struct packed {
      logic enable;
      logic regulator_mode;
      logic sensor_enable;
      logic five_volt;
      logic [1:0] level;
      logic [1:0] startup_step;
      logic [9:0] trip_pct;
   } conv_ctrl_t;

endpackage

// ===== testbench/card_load_model.sv
// Behavioural card load and inductor seen by the converter control outputs
module card_load_model
   import card_supply_pkg::*;
#(
   parameter int RISE_CYC = 20
)
(
   input wire logic pclk,
   input wire conv_ctrl_t conv_ctrl,
   input wire logic short_cmd,
   output logic vout_in_spec,
   output logic overload_sense
);
   timeunit 1ns;
   timeprecision 1ns;

   int rise_cnt = 0;

   // Output ramps up only while the converter is enabled
   always @(posedge pclk) begin
      if (!conv_ctrl.enable) begin
         rise_cnt <= 0;
      end else if (rise_cnt < RISE_CYC) begin
         rise_cnt <= rise_cnt + 1;
      end
   end

   // A short pulls the rail out of spec and drives the limiter
   assign vout_in_spec = conv_ctrl.enable && (rise_cnt == RISE_CYC) && !short_cmd;
   assign overload_sense = short_cmd;
endmodule

// ===== testbench/card_supply_converter_ctrl_test.sv
// Self-checking bench for the card supply converter control block
module card_supply_converter_ctrl_test;
   import card_supply_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic pready, pslverr, err, c, card_present_pin = 0, short_cmd = 0;
   logic vout_in_spec, overload_sense, converter_clk, irq;
   conv_ctrl_t conv_ctrl;
   int n_errors = 0, n_compared = 0;

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
$display("unexpected at %0t: got %0h want %0h", $time, g, e); end end

   always #20 pclk = ~pclk;

   card_supply_converter_ctrl card_supply_converter_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .card_present_pin(card_present_pin), .overload_sense(overload_sense),
      .vout_in_spec(vout_in_spec), .conv_ctrl(conv_ctrl), .converter_clk(converter_clk), .irq(irq));

   card_load_model card_load_model_i (.pclk(pclk), .conv_ctrl(conv_ctrl), .short_cmd(short_cmd),
      .vout_in_spec(vout_in_spec), .overload_sense(overload_sense));

   // ----------------------------------------------------------------
   // Bus and helper tasks
   // ----------------------------------------------------------------
   task wrap_up;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_errors++;
            wrap_up;
         end
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reads status until the masked bits match
   task poll(input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      while ((q & m) !== v) begin
         n++;
         if (n > 200) begin
            n_errors++;
            wrap_up;
         end
         apb(1'b0, OFS_STATUS, 32'h0000_0000);
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK(q[1:0], 2'b00)
      `CHK(conv_ctrl.enable, 1'b0)
      apb(1'b0, OFS_CONVERTER, 32'h0000_0000);
      `CHK(q[3:0], PRESCALE_RST)
      apb(1'b0, OFS_IRQ_MASK, 32'h0000_0000);
      `CHK(q[2:0], IRQ_MASK_RST)
   endtask

   task t_absent;
      apb(1'b1, OFS_CONTROL, 32'h0000_0001);
      cyc(5);
      `CHK(conv_ctrl.enable, 1'b0)
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      `CHK(q[0], 1'b0)
   endtask

   task t_start5v;
      card_present_pin <= 1'b1;
      cyc(8);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, OFS_CONFIG, 32'h0000_0003);
      apb(1'b1, OFS_CONVERTER, 32'h0000_0000);
      apb(1'b1, OFS_CONTROL, 32'h0000_0001);
      cyc(3);
      `CHK(conv_ctrl.enable, 1'b1)
      `CHK(conv_ctrl.sensor_enable, 1'b0)
      `CHK(conv_ctrl.five_volt, 1'b1)
      `CHK(conv_ctrl.trip_pct, TRIP_BASE_PCT)
      repeat (4) begin
         c = converter_clk;
         @(posedge pclk);
         `CHK(converter_clk, ~c)
      end
      poll(32'h0000_0073, 32'h0000_0031);
      `CHK(irq, 1'b1)
      `CHK(conv_ctrl.sensor_enable, 1'b1)
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
      cyc(1);
      `CHK(irq, 1'b0)
      apb(1'b1, OFS_CONVERTER, 32'h0000_0040);
      cyc(3);
      `CHK(conv_ctrl.trip_pct, TRIP_BASE_PCT + TRIP_RAISE_PCT)
   endtask

   task t_trip;
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
      short_cmd <= 1'b1;
      poll(32'h0000_0073, 32'h0000_0062);
      `CHK(conv_ctrl.enable, 1'b0)
      apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
      `CHK(q[1], 1'b1)
      `CHK(irq, 1'b0)
      short_cmd <= 1'b0;
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0007);
   endtask

   task t_boost;
      apb(1'b1, OFS_CONVERTER, 32'h0000_0020);
      apb(1'b1, OFS_CONTROL, 32'h0000_0001);
      cyc(3);
      `CHK(conv_ctrl.startup_step, 2'h2)
      `CHK(conv_ctrl.trip_pct, 10'(TRIP_BASE_PCT * 3))
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK(q[1:0], 2'b00)
      poll(32'h0000_0073, 32'h0000_0031);
      apb(1'b1, OFS_CONVERTER, 32'h0000_0060);
      cyc(3);
      `CHK(conv_ctrl.trip_pct, 10'((TRIP_BASE_PCT + TRIP_RAISE_PCT) * 3))
   endtask

   task t_removal;
      card_present_pin <= 1'b0;
      poll(32'h0000_0074, 32'h0000_0020);
      `CHK(irq, 1'b1)
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      `CHK(q[0], 1'b0)
      poll(32'h0000_0073, 32'h0000_0000);
      `CHK(conv_ctrl.enable, 1'b0)
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0007);
   endtask

   task t_start_overload;
      card_present_pin <= 1'b1;
      short_cmd <= 1'b1;
      cyc(8);
      apb(1'b1, OFS_CONFIG, 32'h0000_0002);
      apb(1'b1, OFS_CONVERTER, 32'h0000_0080);
      apb(1'b1, OFS_CONTROL, 32'h0000_0001);
      cyc(60);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK(q[6:0], 7'h14)
      `CHK(conv_ctrl.regulator_mode, 1'b1)
      `CHK(conv_ctrl.five_volt, 1'b0)
      apb(1'b1, OFS_CONTROL, 32'h0000_0000);
      short_cmd <= 1'b0;
      poll(32'h0000_0070, 32'h0000_0000);
   endtask

   task t_unmapped;
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      `CHK(err, 1'b1)
      apb(1'b0, 8'h18, 32'h0000_0000);
      `CHK(err, 1'b1)
      `CHK(q, 32'h0000_0000)
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK(err, 1'b0)
   endtask

   initial begin
      cyc(8);
      presetn <= 1'b1;
      cyc(2);
      t_reset;
      t_absent;
      t_start5v;
      t_trip;
      t_boost;
      t_removal;
      t_start_overload;
      t_unmapped;
      wrap_up;
   end
endmodule
